// File: core/dla_arbiter.sv
/*
 * dual master lock arbiter: two control copies, ownership arbitration, switch
 * control, manual downstream line drive and the recovery start strobe.
 * assumes each master's register port is already decoded from its upstream
 * slave interface and is synchronous to clk; downstream pins sampled as is.
 */
module dla_arbiter
	import dla_pkg::*;
(
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst_b,
	// master 0 register port
	input  wire logic       m0_wr,
	input  wire logic       m0_rd,
	input  wire logic [7:0] m0_addr,
	input  wire logic [7:0] m0_wdata,
	output logic      [7:0] m0_rdata,
	// master 1 register port
	input  wire logic       m1_wr,
	input  wire logic       m1_rd,
	input  wire logic [7:0] m1_addr,
	input  wire logic [7:0] m1_wdata,
	output logic      [7:0] m1_rdata,
	// internal switches
	output logic      [1:0] switch_closed,
	output logic            recovery_start,
	// downstream open-drain lines
	input  wire logic       ds_data_in,
	output logic            ds_data_out,
	output logic            ds_data_oe,
	input  wire logic       ds_clock_in,
	output logic            ds_clock_out,
	output logic            ds_clock_oe
);
	// ==========================================================
	// reset release
	logic       rst_meta;
	logic       rst_sync_b;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_meta   <= 1'b0;
			rst_sync_b <= 1'b0;
		end else begin
			rst_meta   <= 1'b1;
			rst_sync_b <= rst_meta;
		end
	end

	// ==========================================================
	// gather per master ports into arrays
	logic [1:0]      wr;
	logic [1:0]      rd;
	logic [7:0]      addr [2];
	logic [7:0]      wdata [2];
	logic [7:0]      ctl [2];
	logic [7:0]      next_ctl [2];
	logic [7:0]      rdata [2];
	logic [7:0]      next_rdata [2];
	logic [1:0]      man_data;
	logic [1:0]      next_man_data;
	logic [1:0]      man_clock;
	logic [1:0]      next_man_clock;
	logic [1:0]      grant;
	logic [1:0]      next_grant;
	logic [1:0]      manual_ok;
	dla_owner_t      owner;
	dla_owner_t      next_owner;
	dla_last_t       last;
	dla_last_t       next_last;
	logic            next_rec;
	logic            next_data_oe;
	logic            next_clock_oe;

	assign wr       = {m1_wr, m0_wr};
	assign rd       = {m1_rd, m0_rd};
	assign addr[0]  = m0_addr;
	assign addr[1]  = m1_addr;
	assign wdata[0] = m0_wdata;
	assign wdata[1] = m1_wdata;
	assign m0_rdata = rdata[0];
	assign m1_rdata = rdata[1];
	assign grant    = {owner == DLA_OWN1, owner == DLA_OWN0};

	// ==========================================================
	// arbitration
	always_comb begin
		logic [1:0] req;
		logic [1:0] prec;
		req        = {next_ctl[1][DLA_CTL_REQ], next_ctl[0][DLA_CTL_REQ]};
		// precedence written together with the request must count at that same edge
		prec       = {next_ctl[1][DLA_CTL_PREC], next_ctl[0][DLA_CTL_PREC]};
		next_owner = owner;
		next_last  = last;
		unique case (owner)
			DLA_OWN0: begin
				if (!req[0])
					next_owner = DLA_IDLE;
			end
			DLA_OWN1: begin
				if (!req[1])
					next_owner = DLA_IDLE;
			end
			DLA_IDLE: begin
				// a waiting request is served the cycle after release
				if (req == 2'b01)
					next_owner = DLA_OWN0;
				else if (req == 2'b10)
					next_owner = DLA_OWN1;
				else if (req == 2'b11) begin
					if (prec == 2'b01)
						next_owner = DLA_OWN0;
					else if (prec == 2'b10)
						next_owner = DLA_OWN1;
					else if (prec == 2'b11)
						next_owner = (last == DLA_LAST_M1) ? DLA_OWN0 : DLA_OWN1;
					else
						next_owner = (last == DLA_LAST_M0) ? DLA_OWN1 : DLA_OWN0;
				end
			end
			default: next_owner = DLA_IDLE;
		endcase
		if (next_owner == DLA_OWN0 && owner != DLA_OWN0)
			next_last = DLA_LAST_M0;
		else if (next_owner == DLA_OWN1 && owner != DLA_OWN1)
			next_last = DLA_LAST_M1;
	end

	assign next_grant = {next_owner == DLA_OWN1, next_owner == DLA_OWN0};

	// ==========================================================
	// per master register copies
	for (genvar m = 0; m < 2; m++) begin : g_master
		always_comb begin
			logic [7:0] sts;
			sts               = 8'h00;
			next_ctl[m]       = ctl[m];
			next_man_data[m]  = man_data[m];
			next_man_clock[m] = man_clock[m];
			if (wr[m] && addr[m] == DLA_OFS_CONTROL)
				next_ctl[m] = wdata[m] & DLA_CTL_RW_MASK;
			if (wr[m] && addr[m] == DLA_OFS_STATUS) begin
				next_man_data[m]  = wdata[m][DLA_STS_DATA];
				next_man_clock[m] = wdata[m][DLA_STS_CLOCK];
			end
			// the arm bit is consumed by the join it starts; a rewrite wins
			if (recovery_start && grant[m] &&
			    !(wr[m] && addr[m] == DLA_OFS_CONTROL))
				next_ctl[m][DLA_CTL_ARM] = 1'b0;
			sts[DLA_STS_DATA]  = ds_data_in;
			sts[DLA_STS_CLOCK] = ds_clock_in;
			sts[DLA_STS_OTHER] = grant[1-m];
			next_rdata[m] = rdata[m];
			if (rd[m]) begin
				if (addr[m] == DLA_OFS_CONTROL)
					next_rdata[m] = ctl[m] | (8'(grant[m]) << DLA_CTL_GRANT);
				else if (addr[m] == DLA_OFS_STATUS)
					next_rdata[m] = sts;
				else
					next_rdata[m] = 8'h00;
			end
		end

		always_ff @(posedge clk or negedge rst_sync_b) begin
			if (!rst_sync_b) begin
				ctl[m]       <= DLA_CTL_RESET;
				rdata[m]     <= 8'h00;
				man_data[m]  <= DLA_LINE_RESET;
				man_clock[m] <= DLA_LINE_RESET;
			end else begin
				ctl[m]       <= next_ctl[m];
				rdata[m]     <= next_rdata[m];
				man_data[m]  <= next_man_data[m];
				man_clock[m] <= next_man_clock[m];
			end
		end

		assign manual_ok[m]     = grant[m] && !ctl[m][DLA_CTL_JOIN];
		assign switch_closed[m] = grant[m] && ctl[m][DLA_CTL_JOIN];
	end

	// ==========================================================
	// line drive and recovery strobe
	always_comb begin
		next_data_oe  = 1'b0;
		next_clock_oe = 1'b0;
		next_rec      = 1'b0;
		for (int m = 0; m < 2; m++) begin
			if (next_grant[m] && !next_ctl[m][DLA_CTL_JOIN]) begin
				next_data_oe  = !next_man_data[m];
				next_clock_oe = !next_man_clock[m];
			end
			if (next_grant[m] && next_ctl[m][DLA_CTL_JOIN] && !switch_closed[m] &&
			    next_ctl[m][DLA_CTL_ARM])
				next_rec = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			owner          <= DLA_IDLE;
			last           <= DLA_LAST_NONE;
			ds_data_oe     <= 1'b0;
			ds_clock_oe    <= 1'b0;
			recovery_start <= 1'b0;
		end else begin
			owner          <= next_owner;
			last           <= next_last;
			ds_data_oe     <= next_data_oe;
			ds_clock_oe    <= next_clock_oe;
			recovery_start <= next_rec;
		end
	end

	assign ds_data_out  = 1'b0;
	assign ds_clock_out = 1'b0;

	// ==========================================================
	// checks
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_sync_b);

	// both masters write a request to control in the same cycle
	logic both_req_wr;
	assign both_req_wr = &wr && addr[0] == DLA_OFS_CONTROL && addr[1] == DLA_OFS_CONTROL &&
		wdata[0][DLA_CTL_REQ] && wdata[1][DLA_CTL_REQ];

	a_grant_onehot: assert property (!(grant[0] && grant[1]))
		else $error("both masters granted");
	a_switch_needs: assert property (switch_closed[0] |-> grant[0] && ctl[0][DLA_CTL_JOIN])
		else $error("switch 0 closed without grant and join");
	a_release_drop: assert property (grant[0] && wr[0] && addr[0] == DLA_OFS_CONTROL &&
		!wdata[0][DLA_CTL_REQ] |=> !grant[0] && !switch_closed[0])
		else $error("grant kept after release");
	a_first_tie: assert property (owner == DLA_IDLE && last == DLA_LAST_NONE && both_req_wr &&
		!wdata[0][DLA_CTL_PREC] && !wdata[1][DLA_CTL_PREC] |=> grant[0])
		else $error("tie not given to master 0");
	a_tie_rotate: assert property (owner == DLA_IDLE && last == DLA_LAST_M0 && both_req_wr &&
		!wdata[0][DLA_CTL_PREC] && !wdata[1][DLA_CTL_PREC] |=> grant[1])
		else $error("tie not rotated to master 1");
	a_prec_wins: assert property (owner == DLA_IDLE && both_req_wr &&
		!wdata[0][DLA_CTL_PREC] && wdata[1][DLA_CTL_PREC] |=> grant[1])
		else $error("precedence ignored");
	a_both_prec: assert property (owner == DLA_IDLE && last != DLA_LAST_M1 && both_req_wr &&
		wdata[0][DLA_CTL_PREC] && wdata[1][DLA_CTL_PREC] |=> grant[1])
		else $error("double precedence not given to master 1");
	a_queue_serve: assert property (grant[0] && ctl[1][DLA_CTL_REQ] && !wr[1]
		&& !next_ctl[0][DLA_CTL_REQ] |=> ##1 grant[1])
		else $error("waiting request not served");
	a_manual_data: assert property (manual_ok[0] && !wr[0] && !man_data[0] |=> ds_data_oe)
		else $error("data line not driven low");
	a_manual_gate: assert property (!manual_ok[0] && !manual_ok[1] |->
		!ds_data_oe && !ds_clock_oe)
		else $error("manual drive without a granted unjoined master");
	a_join_quiet: assert property (|switch_closed |-> !ds_data_oe && !ds_clock_oe)
		else $error("manual drive while joined");
	a_read_data: assert property (rd[0] && addr[0] == DLA_OFS_STATUS
		|=> m0_rdata[DLA_STS_DATA] == $past(ds_data_in))
		else $error("data line level misread");
	a_read_clock: assert property (rd[1] && addr[1] == DLA_OFS_STATUS
		|=> m1_rdata[DLA_STS_CLOCK] == $past(ds_clock_in))
		else $error("clock line level misread");
	a_grant_read: assert property (rd[1] && addr[1] == DLA_OFS_CONTROL
		|=> m1_rdata[DLA_CTL_GRANT] == $past(grant[1]))
		else $error("grant bit misread");
	a_recovery_arm: assert property (recovery_start |-> $rose(switch_closed[0]) ||
		$rose(switch_closed[1]))
		else $error("recovery start without new join");
endmodule : dla_arbiter

// File: core/dla_pkg.sv
/*
 * constants for the dual master lock arbiter: register offsets, field positions,
 * reset values and the ownership state encodings.
 * assumes a single 40 MHz clock domain and one register port per upstream master.
 */
//
// Function
// - with downstream_recovery_arm set, the next join of the granted master starts recovery.
// - a master's switch is closed only while its join request and its grant are both one.
// - ownership_granted reads one only for the master that currently owns the bus.
// - writing zero to ownership_request drops the grant and opens the switch.
// - equal zero precedence grants master 0 first, then the one not granted last.
// - unequal precedence lets the one bit win; both one favour master 1 unless it was last.
// - reading data_line_manual returns the present downstream data line level.
// - writing zero to data_line_manual pulls the data line low, one releases it.
// - reading clock_line_manual returns the present downstream clock line level.
// - writing zero to clock_line_manual pulls the clock line low, one releases it.
// - manual line control acts only when join request is zero and grant is one.
// - each master reaches only its own copy of the control register.
package dla_pkg;
	// ==========================================================
	// register offsets
	localparam logic [7:0] DLA_OFS_CONTROL = 8'h01;
	localparam logic [7:0] DLA_OFS_STATUS  = 8'h02;
	// ==========================================================
	// arbiter_control fields
	localparam int DLA_CTL_PREC   = 7;
	localparam int DLA_CTL_ARM    = 3;
	localparam int DLA_CTL_JOIN   = 2;
	localparam int DLA_CTL_GRANT  = 1;
	localparam int DLA_CTL_REQ    = 0;
	localparam logic [7:0] DLA_CTL_RW_MASK = 8'hFD;
	localparam logic [7:0] DLA_CTL_RESET   = 8'h00;
	// ==========================================================
	// arbiter_status fields
	localparam int DLA_STS_DATA  = 7;
	localparam int DLA_STS_CLOCK = 6;
	localparam int DLA_STS_OTHER = 0;
	localparam logic       DLA_LINE_RESET = 1'b0;
	// ==========================================================
	// ownership states, gray along idle -> owner -> idle
	typedef enum logic [1:0] {
		DLA_IDLE = 2'b00,
		DLA_OWN0 = 2'b01,
		DLA_OWN1 = 2'b10
	} dla_owner_t;
	typedef enum logic [1:0] {
		DLA_LAST_NONE = 2'b00,
		DLA_LAST_M0   = 2'b01,
		DLA_LAST_M1   = 2'b11
	} dla_last_t;
endpackage : dla_pkg

// File: tb/dla_ds_model.sv
/*
 * downstream bus model: two open-drain lines with pull-ups, plus a far slave
 * that can hold the data line low.
 * assumes oe high means the arbiter pulls the line low.
 */
module dla_ds_model (
	// arbiter drive
	input  wire logic ds_data_oe,
	input  wire logic ds_clock_oe,
	// far slave holding data low
	input  wire logic slave_hold,
	// resolved line levels
	output logic      ds_data_lvl,
	output logic      ds_clock_lvl
);
	timeunit 1ns;
	timeprecision 100ps;
	// ==========================================================
	// wired-and with pull-up: a released line reads high, never the old value
	assign ds_data_lvl  = !(ds_data_oe || slave_hold);
	assign ds_clock_lvl = !ds_clock_oe;
endmodule : dla_ds_model

// File: tb/dual_master_lock_arbiter_tb_top.sv
/*
 * self-checking bench for the arbiter: both register ports, the switches, the
 * recovery strobe and the manual drive of the downstream lines.
 * assumes the downstream model resolves the open-drain lines.
 */
module dual_master_lock_arbiter_tb_top;
	import dla_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;
	logic       clk, rst_b, m0_wr, m0_rd, m1_wr, m1_rd, slave_hold;
	logic [7:0] m0_addr, m0_wdata, m0_rdata, m1_addr, m1_wdata, m1_rdata;
	logic [1:0] switch_closed;
	logic       recovery_start, d_lvl, d_out, d_oe, c_lvl, c_out, c_oe;
	int         errors, comparisons;
	// {p1,p0} and the expected winner for each arbitration step
	logic [1:0] prec [8] = '{2'b00, 2'b00, 2'b00, 2'b10, 2'b01, 2'b11, 2'b11, 2'b11};
	logic [1:0] win  [8] = '{2'b01, 2'b10, 2'b01, 2'b10, 2'b01, 2'b10, 2'b01, 2'b10};

	dla_arbiter i_dut (.clk(clk), .rst_b(rst_b),
		.m0_wr(m0_wr), .m0_rd(m0_rd), .m0_addr(m0_addr), .m0_wdata(m0_wdata),
		.m0_rdata(m0_rdata), .m1_wr(m1_wr), .m1_rd(m1_rd), .m1_addr(m1_addr),
		.m1_wdata(m1_wdata), .m1_rdata(m1_rdata), .switch_closed(switch_closed),
		.recovery_start(recovery_start), .ds_data_in(d_lvl), .ds_data_out(d_out),
		.ds_data_oe(d_oe), .ds_clock_in(c_lvl), .ds_clock_out(c_out), .ds_clock_oe(c_oe));
	dla_ds_model i_bus (.ds_data_oe(d_oe), .ds_clock_oe(c_oe), .slave_hold(slave_hold),
		.ds_data_lvl(d_lvl), .ds_clock_lvl(c_lvl));

	// ==========================================================
	// helpers
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	// one access per selected port, both on the same edge when both selected
	task automatic xfer(input logic [1:0] wr, input logic [1:0] rd, input logic [7:0] a,
			input logic [7:0] d0, input logic [7:0] d1);
		@(posedge clk);
		{m1_wr, m0_wr} <= wr;
		{m1_rd, m0_rd} <= rd;
		m0_addr <= a;
		m1_addr <= a;
		m0_wdata <= d0;
		m1_wdata <= d1;
		@(posedge clk);
		{m1_wr, m0_wr} <= 2'b00;
		{m1_rd, m0_rd} <= 2'b00;
		#1;
	endtask : xfer

	task automatic do_reset();
		rst_b <= 1'b0;
		repeat (4) @(posedge clk);
		rst_b <= 1'b1;
		repeat (4) @(posedge clk);
	endtask : do_reset

	task automatic wrap_up();
		$display("errors=%0d comparisons=%0d", errors, comparisons);
		if (errors == 0 && comparisons > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : wrap_up

	// ==========================================================
	// clock and watchdog
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	initial begin
		#(25 * 3000);
		errors++;
		wrap_up();
	end

	// ==========================================================
	// scenarios
	initial begin
		{m0_wr, m0_rd, m1_wr, m1_rd} = 4'h0;
		{m0_addr, m0_wdata, m1_addr, m1_wdata} = 32'h0;
		rst_b = 1'b0;
		slave_hold = 1'b0;
		do_reset();
		xfer(2'b00, 2'b11, DLA_OFS_CONTROL, 8'h00, 8'h00);
		check(m0_rdata, DLA_CTL_RESET);
		check(m1_rdata, DLA_CTL_RESET);
		check({6'h00, d_out, c_out}, 8'h00);
		// master 0 owns with join off: manual latches pull both lines low
		xfer(2'b01, 2'b00, DLA_OFS_CONTROL, 8'h01, 8'h00);
		check({6'h00, d_oe, c_oe}, 8'h03);
		xfer(2'b00, 2'b11, DLA_OFS_STATUS, 8'h00, 8'h00);
		check(m0_rdata, 8'h00);
		check(m1_rdata, 8'h01);
		// a master without the grant cannot drive the lines
		xfer(2'b10, 2'b00, DLA_OFS_STATUS, 8'h00, 8'hC0);
		check({6'h00, d_oe, c_oe}, 8'h03);
		slave_hold <= 1'b1;
		xfer(2'b01, 2'b00, DLA_OFS_STATUS, 8'hC0, 8'h00);
		check({6'h00, d_oe, c_oe}, 8'h00);
		xfer(2'b00, 2'b01, DLA_OFS_STATUS, 8'h00, 8'h00);
		check(m0_rdata, 8'h40);
		slave_hold <= 1'b0;
		xfer(2'b01, 2'b00, DLA_OFS_STATUS, 8'h80, 8'h00);
		check({6'h00, d_oe, c_oe}, 8'h01);
		xfer(2'b00, 2'b01, DLA_OFS_STATUS, 8'h00, 8'h00);
		check(m0_rdata, 8'h80);
		// unmapped place: write ignored, reads zero
		xfer(2'b01, 2'b00, 8'h05, 8'hFF, 8'h00);
		xfer(2'b00, 2'b01, 8'h05, 8'h00, 8'h00);
		check(m0_rdata, 8'h00);
		// arm recovery, queue master 1, then join master 0
		xfer(2'b11, 2'b00, DLA_OFS_CONTROL, 8'h09, 8'h01);
		check({6'h00, switch_closed}, 8'h00);
		xfer(2'b01, 2'b00, DLA_OFS_CONTROL, 8'h0D, 8'h00);
		check({7'h00, recovery_start}, 8'h01);
		check({6'h00, switch_closed}, 8'h01);
		check({6'h00, d_oe, c_oe}, 8'h00);
		// arm is consumed by the join: reads back cleared, strobe is one cycle
		xfer(2'b00, 2'b01, DLA_OFS_CONTROL, 8'h00, 8'h00);
		check(m0_rdata, 8'h07);
		check({7'h00, recovery_start}, 8'h00);
		xfer(2'b01, 2'b00, DLA_OFS_CONTROL, 8'h00, 8'h00);
		check({6'h00, switch_closed}, 8'h00);
		xfer(2'b00, 2'b11, DLA_OFS_CONTROL, 8'h00, 8'h00);
		check(m0_rdata, 8'h00);
		check(m1_rdata, 8'h03);
		xfer(2'b10, 2'b00, DLA_OFS_CONTROL, 8'h00, 8'h00);
		// simultaneous requests over every precedence and history case
		for (int i = 0; i < 8; i++) begin
			if (i == 0 || i == 7) begin
				do_reset();
			end
			xfer(2'b11, 2'b00, DLA_OFS_CONTROL, {prec[i][0], 7'h05}, {prec[i][1], 7'h05});
			check({6'h00, switch_closed}, {6'h00, win[i]});
			xfer(2'b11, 2'b00, DLA_OFS_CONTROL, 8'h00, 8'h00);
			check({6'h00, switch_closed}, 8'h00);
		end
		wrap_up();
	end
endmodule : dual_master_lock_arbiter_tb_top
